// ### hdl/rch_defines.vh
/*
 Constants of the rotate-through-carry and hub read execution block:
 instruction fields, opcodes, register offsets, reset values, timing.
 Assumes it is included by bare name from every design file.
*/
// What this block does
// RQ1 - Rotate-carry-left shifts the value left and fills each freed low bit with the carry held at the start.
// RQ2 - With carry writing on rotate-carry-left, carry becomes the original bit 31 of the value.
// RQ3 - Rotate-carry-right shifts the value right and fills each freed high bit with the carry held at the start.
// RQ4 - With carry writing on rotate-carry-right, carry becomes the original bit 0 of the value.
// RQ5 - On either rotate with zero writing, zero is set when the rotated result is zero, else cleared.
// RQ6 - Either rotate stores its result to the destination unless no-result is chosen, then only flags change.
// RQ7 - The rotate count is a source register or a nine-bit literal, chosen by the immediate bit.
// RQ8 - Opcode 001100 is rotate-carry-right, carry from bit 0, result written, done in 4 cycles.
// RQ9 - A byte read waits for the hub slot, fetches the byte, clears bits above bit 7 and stores it.
// RQ10 - A word read clears address bit 0 and stores the sixteen fetched bits zero-extended.
// RQ11 - A long read clears address bits 1 and 0 and stores the whole fetched 32-bit value.
// RQ12 - A read address is a source register or a nine-bit literal.
// RQ13 - A read with zero writing sets zero when the fetched value is zero; with carry writing, carry clears.
// RQ14 - A read always writes its destination; a cleared result bit makes the opcode a hub write instead; here it is refused and sets bad.
// RQ15 - Opcodes 000000, 000001 and 000010 are byte, word and long hub accesses.
// RQ16 - Every hub read takes from 7 to 22 cycles, set by where the core stands in its hub window.
// RQ17 - A count taken from a register uses only its low five bits, 0 to 31.
`ifndef RCH_DEFINES_VH
`define RCH_DEFINES_VH

// instruction word fields
`define RCH_F_OP_HI 31
`define RCH_F_OP_LO 26
`define RCH_F_ZW 25
`define RCH_F_CW 24
`define RCH_F_RW 23
`define RCH_F_IMM 22
`define RCH_F_DST_HI 17
`define RCH_F_DST_LO 9
`define RCH_F_SRC_HI 8
`define RCH_F_SRC_LO 0

// opcodes
`define RCH_OP_BYTE 6'h00
`define RCH_OP_WORD 6'h01
`define RCH_OP_LONG 6'h02
`define RCH_OP_RCR 6'h0C
`define RCH_OP_RCL 6'h0D

// access sizes, equal to the low opcode bits of the hub reads
`define RCH_SZ_BYTE 2'h0
`define RCH_SZ_WORD 2'h1
`define RCH_SZ_LONG 2'h2

// register offsets (byte addresses); bit 11 selects the register file
`define RCH_REG_INSTR 12'h000
`define RCH_REG_FLAGS 12'h004
`define RCH_REG_STATUS 12'h008
`define RCH_REG_HUBLAT 12'h00C
`define RCH_RAM_SEL_BIT 11

// flag and status bit positions
`define RCH_FLAG_C 0
`define RCH_FLAG_Z 1
`define RCH_ST_BUSY 0
`define RCH_ST_DONE 1
`define RCH_ST_BAD 2

// reset values
`define RCH_RST_INSTR 32'h0000_0000
`define RCH_RST_FLAGS 1'b0

// timing
`define RCH_CLK_NS 100
`define RCH_ROT_CYC 3'h4
`define RCH_HUB_MIN 5'h07
`define RCH_HUB_MAX 5'h16
`define RCH_HUB_SETUP (`RCH_HUB_MIN - 5'h03)
`define RCH_OWN_SLOT 4'h0

`endif

// ### hdl/rch_rotator.v
/*
 Combinational rotate-through-carry for both directions.
 Assumes count and carry are held stable by the caller.
*/
`timescale 1ns/100ps
`include "rch_defines.vh"

module rch_rotator (
   input wire [31:0] value_i,
   input wire [4:0] count_i,
   input wire carry_i,
   input wire left_i,
   output wire [31:0] result_o,
   output wire carry_o,
   output wire zero_o
);
   wire [31:0] shifted;
   wire [31:0] fill;

   assign shifted = left_i ? (value_i << count_i) : (value_i >> count_i);

   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1)
      begin : g_fill
         // RQ1 RQ3 carry fills freed bits
         assign fill[i] = carry_i & (left_i ? (i < count_i)
                                            : (i >= 32 - count_i));
      end
   endgenerate

   assign result_o = shifted | fill;
   // RQ2 RQ4 carry from edge bit
   assign carry_o = left_i ? value_i[31] : value_i[0];
   // RQ5 zero test
   assign zero_o = (result_o == 32'h0000_0000);
endmodule

// ### hdl/rch_hub_format.v
/*
 Picks the addressed byte or word out of a fetched hub long and
 zero-extends it. Assumes little-endian lanes inside the long.
*/
`timescale 1ns/100ps
`include "rch_defines.vh"

module rch_hub_format (
   input wire [31:0] long_i,
   input wire [1:0] addr_i,
   input wire [1:0] size_i,
   output reg [31:0] value_o
);
   always @*
   begin
      case (size_i)
         // RQ9 byte zero-extended
         `RCH_SZ_BYTE:
            value_o = {24'h00_0000, long_i[addr_i*8 +: 8]};
         // RQ10 word zero-extended
         `RCH_SZ_WORD:
            value_o = {16'h0000, long_i[addr_i[1]*16 +: 16]};
         default:
            value_o = long_i;
      endcase
   end
endmodule

// ### hdl/rch_exec.v
/*
 Execution unit for rotate-through-carry and hub reads, with a core
 register file of 512 longs and a classic Wishbone slave for software.
 Assumes hub memory returns the addressed long in the cycle after
 hub_req_o is high, on the same clock.
*/
`timescale 1ns/100ps
`include "rch_defines.vh"

module rch_exec (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg hub_req_o,
   output reg [15:0] hub_addr_o,
   input wire [31:0] hub_rdata_i,
   output reg busy_o
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ROT = 3'h1;
   localparam [2:0] ST_HWAIT = 3'h2;
   localparam [2:0] ST_HREQ = 3'h3;
   localparam [2:0] ST_HDATA = 3'h4;
   localparam [2:0] ROT_LAST = `RCH_ROT_CYC - 3'h1;

   // byte-lane merge for bus writes
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] sel;
      integer k;
      begin
         merge = old_v;
         for (k = 0; k < 4; k = k + 1)
            if (sel[k])
               merge[k*8 +: 8] = new_v[k*8 +: 8];
      end
   endfunction

   // RQ15 hub access decode
   function is_hub;
      input [5:0] op;
      begin
         is_hub = (op == `RCH_OP_BYTE) || (op == `RCH_OP_WORD) ||
                  (op == `RCH_OP_LONG);
      end
   endfunction

   // register file of the core
   reg [31:0] ram_q [0:511];

   reg [2:0] state_q;
   reg [31:0] instr_q;
   reg c_flag_q;
   reg z_flag_q;
   reg done_q;
   reg bad_q;
   reg [4:0] hub_lat_q;
   reg [4:0] elapsed_q;
   reg [3:0] slot_q;
   reg [2:0] rot_cnt_q;
   reg [31:0] op_d_q;
   reg [4:0] op_n_q;
   reg c_in_q;
   reg left_q;
   reg [8:0] dst_q;
   reg zw_q;
   reg cw_q;
   reg rw_q;
   reg [1:0] size_q;

   // bus side decode
   wire wb_req;
   wire wb_wr;
   wire is_ram;
   wire [8:0] ram_idx;
   wire [31:0] instr_new;
   wire [5:0] new_op;
   wire [31:0] new_dst_v;
   wire [31:0] new_src_v;
   wire launch;
   wire exec_wr;
   wire exec_done;
   wire wb_go;
   wire [31:0] exec_val;
   wire [31:0] rot_res;
   wire rot_c;
   wire rot_z;
   wire [31:0] fmt_val;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i;
   assign is_ram = wb_adr_i[`RCH_RAM_SEL_BIT];
   assign ram_idx = wb_adr_i[10:2];
   assign instr_new = merge(instr_q, wb_dat_i, wb_sel_i);
   assign new_op = instr_new[`RCH_F_OP_HI:`RCH_F_OP_LO];
   assign new_dst_v = ram_q[instr_new[`RCH_F_DST_HI:`RCH_F_DST_LO]];
   // RQ7 RQ12 immediate or register source
   assign new_src_v = instr_new[`RCH_F_IMM] ?
      {23'h00_0000, instr_new[`RCH_F_SRC_HI:`RCH_F_SRC_LO]} :
      ram_q[instr_new[`RCH_F_SRC_HI:`RCH_F_SRC_LO]];

   assign launch = wb_wr & ~is_ram &
                   (wb_adr_i[7:0] == `RCH_REG_INSTR) &
                   (state_q == ST_IDLE);

   assign exec_done = ((state_q == ST_ROT) && (rot_cnt_q == ROT_LAST)) ||
                      (state_q == ST_HDATA);
   // RQ6 no-result keeps destination; RQ14 reads always write
   assign exec_wr = ((state_q == ST_ROT) && (rot_cnt_q == ROT_LAST) &&
                     rw_q) || (state_q == ST_HDATA);
   assign exec_val = (state_q == ST_ROT) ? rot_res : fmt_val;

   // a bus write into the register file waits while execution writes it
   assign wb_go = wb_req & ~(wb_we_i & is_ram & exec_wr);

   rch_rotator u_rot (
      .value_i(op_d_q),
      .count_i(op_n_q),
      .carry_i(c_in_q),
      .left_i(left_q),
      .result_o(rot_res),
      .carry_o(rot_c),
      .zero_o(rot_z)
   );

   rch_hub_format u_fmt (
      .long_i(hub_rdata_i),
      .addr_i(hub_addr_o[1:0]),
      .size_i(size_q),
      .value_o(fmt_val)
   );

   // register file writes: execution first, then bus
   always @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (exec_wr)
            ram_q[dst_q] <= exec_val;
         else if (wb_go && wb_we_i && is_ram)
            ram_q[ram_idx] <= merge(ram_q[ram_idx], wb_dat_i, wb_sel_i);
      end
   end

   // bus answer, one cycle after the request is seen
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         wb_ack_o <= wb_go;
         if (wb_go && !wb_we_i)
         begin
            if (is_ram)
               wb_dat_o <= ram_q[ram_idx];
            else
               case (wb_adr_i[7:0])
                  `RCH_REG_INSTR:
                     wb_dat_o <= instr_q;
                  `RCH_REG_FLAGS:
                     wb_dat_o <= {30'h0000_0000, z_flag_q, c_flag_q};
                  `RCH_REG_STATUS:
                     wb_dat_o <= {29'h0000_0000, bad_q, done_q, busy_o};
                  `RCH_REG_HUBLAT:
                     wb_dat_o <= {27'h000_0000, hub_lat_q};
                  default:
                     wb_dat_o <= 32'h0000_0000;
               endcase
         end
      end
   end

   // hub window position, free running
   always @(posedge clk_i)
   begin
      if (rst_i)
         slot_q <= 4'h0;
      else if (ce_i)
         slot_q <= slot_q + 4'h1;
   end

   // flags: execution wins over a bus write in the same cycle
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         c_flag_q <= `RCH_RST_FLAGS;
         z_flag_q <= `RCH_RST_FLAGS;
      end
      else if (ce_i)
      begin
         if (wb_go && wb_we_i && !is_ram &&
             (wb_adr_i[7:0] == `RCH_REG_FLAGS))
         begin
            if (wb_sel_i[0])
            begin
               c_flag_q <= wb_dat_i[`RCH_FLAG_C];
               z_flag_q <= wb_dat_i[`RCH_FLAG_Z];
            end
         end
         if (state_q == ST_ROT && rot_cnt_q == ROT_LAST)
         begin
            // RQ2 RQ4 carry out at completion
            if (cw_q)
               c_flag_q <= rot_c;
            // RQ5 zero from rotated result
            if (zw_q)
               z_flag_q <= rot_z;
         end
         else if (state_q == ST_HDATA)
         begin
            // RQ13 carry cleared on reads
            if (cw_q)
               c_flag_q <= 1'b0;
            // RQ13 zero from fetched value
            if (zw_q)
               z_flag_q <= (fmt_val == 32'h0000_0000);
         end
      end
   end

   // sticky status bits; a set in the clearing cycle wins
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_q <= 1'b0;
         bad_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wb_go && wb_we_i && !is_ram &&
             (wb_adr_i[7:0] == `RCH_REG_STATUS) && wb_sel_i[0])
         begin
            if (wb_dat_i[`RCH_ST_DONE])
               done_q <= 1'b0;
            if (wb_dat_i[`RCH_ST_BAD])
               bad_q <= 1'b0;
         end
         if (exec_done)
            done_q <= 1'b1;
         if (wb_go && wb_we_i && !is_ram &&
             (wb_adr_i[7:0] == `RCH_REG_INSTR) && !launch)
            bad_q <= 1'b1;
         // RQ14 write forms are not executed here
         if (launch && !(new_op == `RCH_OP_RCL || new_op == `RCH_OP_RCR ||
             (is_hub(new_op) && instr_new[`RCH_F_RW])))
            bad_q <= 1'b1;
      end
   end

   // sequencer
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         instr_q <= `RCH_RST_INSTR;
         busy_o <= 1'b0;
         hub_req_o <= 1'b0;
         hub_addr_o <= 16'h0000;
         hub_lat_q <= 5'h00;
         elapsed_q <= 5'h00;
         rot_cnt_q <= 3'h0;
         op_d_q <= 32'h0000_0000;
         op_n_q <= 5'h00;
         c_in_q <= 1'b0;
         left_q <= 1'b0;
         dst_q <= 9'h000;
         zw_q <= 1'b0;
         cw_q <= 1'b0;
         rw_q <= 1'b0;
         size_q <= `RCH_SZ_LONG;
      end
      else if (ce_i)
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (launch)
               begin
                  instr_q <= instr_new;
                  dst_q <= instr_new[`RCH_F_DST_HI:`RCH_F_DST_LO];
                  zw_q <= instr_new[`RCH_F_ZW];
                  cw_q <= instr_new[`RCH_F_CW];
                  rw_q <= instr_new[`RCH_F_RW];
                  op_d_q <= new_dst_v;
                  // RQ17 only low five count bits
                  op_n_q <= new_src_v[4:0];
                  // RQ1 RQ3 carry before the instruction
                  c_in_q <= c_flag_q;
                  rot_cnt_q <= 3'h0;
                  elapsed_q <= 5'h00;
                  size_q <= new_op[1:0];
                  if (new_op == `RCH_OP_RCL || new_op == `RCH_OP_RCR)
                  begin
                     // RQ8 opcode 001100 rotates right
                     left_q <= (new_op == `RCH_OP_RCL);
                     busy_o <= 1'b1;
                     state_q <= ST_ROT;
                  end
                  else if (is_hub(new_op) && instr_new[`RCH_F_RW])
                  begin
                     busy_o <= 1'b1;
                     state_q <= ST_HWAIT;
                     case (new_op[1:0])
                        `RCH_SZ_BYTE:
                           hub_addr_o <= new_src_v[15:0];
                        // RQ10 word aligned
                        `RCH_SZ_WORD:
                           hub_addr_o <= {new_src_v[15:1], 1'b0};
                        // RQ11 long aligned
                        default:
                           hub_addr_o <= {new_src_v[15:2], 2'h0};
                     endcase
                  end
               end
            end
            ST_ROT:
            begin
               // RQ8 fixed four-cycle rotate
               rot_cnt_q <= rot_cnt_q + 3'h1;
               if (rot_cnt_q == ROT_LAST)
               begin
                  busy_o <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            ST_HWAIT:
            begin
               elapsed_q <= elapsed_q + 5'h01;
               // RQ9 RQ16 wait for own hub slot
               if (elapsed_q >= `RCH_HUB_SETUP && slot_q == `RCH_OWN_SLOT)
               begin
                  hub_req_o <= 1'b1;
                  state_q <= ST_HREQ;
               end
            end
            ST_HREQ:
            begin
               elapsed_q <= elapsed_q + 5'h01;
               hub_req_o <= 1'b0;
               state_q <= ST_HDATA;
            end
            ST_HDATA:
            begin
               // RQ16 latency seen by software
               hub_lat_q <= elapsed_q + 5'h01;
               busy_o <= 1'b0;
               state_q <= ST_IDLE;
            end
            default:
            begin
               hub_req_o <= 1'b0;
               busy_o <= 1'b0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ### tb/rch_exec_assertions.sv
/*
 Port checker for rch_exec: bus handshake, instruction run lengths,
 hub request timing and alignment.
 Assumes bench keeps one request per bus cycle.
*/
`timescale 1ns/100ps
module rch_exec_checker (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   input wire hub_req_o,
   input wire [15:0] hub_addr_o,
   input wire busy_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire [5:0] op_w = wb_dat_i[31:26];
   wire take_w = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & ce_i
      & (wb_adr_i == 12'h000) & ~busy_o;
   wire rot_w = take_w & (op_w == 6'h0C | op_w == 6'h0D);
   wire hub_w = take_w & wb_dat_i[23] & (op_w <= 6'h02);
   wire bad_w = take_w & ~rot_w & ~hub_w;
   reg [5:0] op_q;
   // opcode of the instruction in flight
   always @(posedge clk_i)
   begin
      if (rst_i)
         op_q <= 6'h3F;
      else if (take_w)
         op_q <= op_w;
   end
   sequence s_rot_run;
      busy_o [*4] ##1 !busy_o;
   endsequence
   sequence s_hub_run;
      busy_o [*7] ##[1:16] !busy_o;
   endsequence
   // request seen at R+1; busy still sampled high at R+2, low at R+3
   sequence s_req_tail;
      busy_o ##1 !busy_o;
   endsequence
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_bounded: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |-> ##[1:2] wb_ack_o)
      else $error("bus request not answered");
   a_rot_four: assert property (rot_w |=> s_rot_run)
      else $error("rotate did not take four cycles");
   a_hub_window: assert property (hub_w |=> s_hub_run)
      else $error("hub read outside its cycle window");
   a_req_pulse: assert property (hub_req_o |=> !hub_req_o)
      else $error("hub request longer than one cycle");
   a_req_finish: assert property (hub_req_o |=> s_req_tail)
      else $error("hub read did not end after its slot");
   a_word_align: assert property (
      hub_req_o && op_q == 6'h01 |-> !hub_addr_o[0])
      else $error("word address not aligned");
   a_long_align: assert property (
      hub_req_o && op_q == 6'h02 |-> hub_addr_o[1:0] == 2'h0)
      else $error("long address not aligned");
   a_addr_hold: assert property (busy_o && $past(busy_o)
      && op_q <= 6'h02 |-> $stable(hub_addr_o))
      else $error("hub address moved during read");
   a_refuse_idle: assert property (bad_w |=> !busy_o [*2])
      else $error("refused instruction started");
endmodule

bind rch_exec rch_exec_checker u_chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o),
   .hub_req_o(hub_req_o),
   .hub_addr_o(hub_addr_o),
   .busy_o(busy_o)
);

// ### tb/rch_hub_mem.sv
/*
 Behavioural hub memory of 128 longs, indexed by byte address bits 8:2.
 Assumes the core samples read data one cycle after its request.
*/
`timescale 1ns/100ps
module rch_hub_mem (
   input wire clk_i,
   input wire hub_req_i,
   input wire [15:0] hub_addr_i,
   output reg [31:0] hub_rdata_o
);
   reg [31:0] mem_q [0:127];
   initial hub_rdata_o = 32'h5A5A_A5A5;
   task load(input [6:0] idx, input [31:0] val);
      mem_q[idx] = val;
   endtask
   // one-cycle data answer
   // outside the answer cycle the bus toggles, so stale data never matches
   always @(posedge clk_i)
   begin
      if (hub_req_i)
         hub_rdata_o <= mem_q[hub_addr_i[8:2]];
      else
         hub_rdata_o <= ~hub_rdata_o;
   end
endmodule

// ### tb/tb_rotate_carry_and_hub_read_exec.sv
/*
 Self-checking bench for rch_exec: rotates, hub reads and refusals.
 Assumes the checker is bound and the hub model answers reads.
*/
`timescale 1ns/100ps
module tb_rotate_carry_and_hub_read_exec;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg ce_i = 1'b1;
   reg wb_cyc_i = 1'b0;
   reg wb_stb_i = 1'b0;
   reg wb_we_i = 1'b0;
   reg [11:0] wb_adr_i = 12'h000;
   reg [3:0] wb_sel_i = 4'hF;
   reg [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire [31:0] hub_rdata_i;
   wire [15:0] hub_addr_o;
   wire wb_ack_o;
   wire hub_req_o;
   wire busy_o;
   integer n_errors = 0;
   integer checks = 0;
   integer cyc_cnt = 0;
   reg [31:0] rd;
   rch_exec DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hub_req_o(hub_req_o),
      .hub_addr_o(hub_addr_o), .hub_rdata_i(hub_rdata_i),
      .busy_o(busy_o));
   rch_hub_mem u_mem (.clk_i(clk_i), .hub_req_i(hub_req_o),
      .hub_addr_i(hub_addr_o), .hub_rdata_o(hub_rdata_i));
   initial forever #50 clk_i = ~clk_i;

   task check_val(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp)
         begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task summarize;
      begin
         $display("checks %0d n_errors %0d", checks, n_errors);
         if (n_errors == 0 && checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   // one classic cycle; waits for ack, takes data at that edge
   task wb(input we, input [11:0] adr, input [31:0] dat);
      integer i;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= adr;
         wb_dat_i <= dat;
         i = 0;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1 && i < 20)
         begin
            @(posedge clk_i);
            i = i + 1;
         end
         if (i == 20)
            check_val(32'h0, 32'h1);
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask

   task run(input [31:0] instr);
      integer i;
      begin
         wb(1'b1, 12'h000, instr);
         i = 0;
         while (busy_o !== 1'b0 && i < 40)
         begin
            @(posedge clk_i);
            i = i + 1;
         end
         if (i == 40)
            check_val(32'h0, 32'h2);
      end
   endtask

   // dest is register 5, register-sourced count sits in register 6
   task rot_case(input [5:0] op, input rw, input imm, input [31:0] d,
      input [31:0] cnt, input c, input [31:0] ed, input ez, input ec);
      begin
         wb(1'b1, 12'h814, d);
         if (!imm)
            wb(1'b1, 12'h818, cnt);
         wb(1'b1, 12'h004, {30'h0, ~ez, c});
         run({op, 2'b11, rw, imm, 4'hF, 9'd5, imm ? cnt[8:0] : 9'd6});
         wb(1'b0, 12'h814, 32'h0);
         check_val(rd, rw ? ed : d);
         wb(1'b0, 12'h004, 32'h0);
         check_val(rd, {30'h0, ez, ec});
      end
   endtask

   task hub_case(input [5:0] op, input imm, input [31:0] src,
      input [31:0] ed, input ez);
      begin
         wb(1'b1, 12'h814, 32'hFFFF_FFFF);
         if (!imm)
            wb(1'b1, 12'h818, src);
         wb(1'b1, 12'h004, {30'h0, ~ez, 1'b1});
         run({op, 3'b111, imm, 4'hF, 9'd5, imm ? src[8:0] : 9'd6});
         wb(1'b0, 12'h814, 32'h0);
         check_val(rd, ed);
         wb(1'b0, 12'h004, 32'h0);
         check_val(rd, {30'h0, ez, 1'b0});
         wb(1'b0, 12'h00C, 32'h0);
         check_val(rd >= 7 && rd <= 22, 32'h1);
      end
   endtask

   task t_rotate_left;
      begin
         rot_case(6'h0D, 1, 1, 32'h8000_0000, 0, 1, 32'h8000_0000, 0, 1);
         rot_case(6'h0D, 1, 1, 32'h8000_0000, 1, 0, 32'h0, 1, 1);
         rot_case(6'h0D, 1, 1, 32'h8000_0000, 1, 1, 32'h1, 0, 1);
         rot_case(6'h0D, 1, 1, 32'h2108_4048, 2, 0, 32'h8421_0120, 0, 0);
         rot_case(6'h0D, 1, 1, 32'h2108_4048, 2, 1, 32'h8421_0123, 0, 0);
         rot_case(6'h0D, 1, 1, 32'h8765_4321, 4, 0, 32'h7654_3210, 0, 1);
         rot_case(6'h0D, 1, 1, 32'h8765_4321, 4, 1, 32'h7654_321F, 0, 1);
         rot_case(6'h0D, 1, 1, 32'h0000_0001, 31, 1, 32'hFFFF_FFFF, 0, 0);
      end
   endtask

   task t_rotate_right;
      begin
         rot_case(6'h0C, 1, 1, 32'h1, 0, 0, 32'h1, 0, 1);
         rot_case(6'h0C, 1, 1, 32'h1, 1, 0, 32'h0, 1, 1);
         rot_case(6'h0C, 1, 1, 32'h1, 1, 1, 32'h8000_0000, 0, 1);
         rot_case(6'h0C, 1, 1, 32'h18C2_1084, 2, 0, 32'h0630_8421, 0, 0);
         rot_case(6'h0C, 1, 1, 32'h18C2_1084, 2, 1, 32'hC630_8421, 0, 0);
         rot_case(6'h0C, 1, 1, 32'h8765_4321, 4, 0, 32'h0876_5432, 0, 1);
         rot_case(6'h0C, 1, 1, 32'h8765_4321, 4, 1, 32'hF876_5432, 0, 1);
      end
   endtask

   // count from a register or a wide literal keeps only five bits
   task t_count_source;
      begin
         rot_case(6'h0C, 1, 0, 32'h8765_4321, 32'h24, 1,
            32'hF876_5432, 0, 1);
         rot_case(6'h0D, 1, 1, 32'h8765_4321, 32'h1E4, 0,
            32'h7654_3210, 0, 1);
      end
   endtask

   task t_no_result;
      begin
         rot_case(6'h0D, 0, 1, 32'h8000_0000, 1, 0, 32'h0, 1, 1);
         rot_case(6'h0C, 0, 1, 32'h1, 1, 1, 32'h8000_0000, 0, 1);
      end
   endtask

   task t_hub_reads;
      begin
         u_mem.load(7'h10, 32'h8877_6655);
         u_mem.load(7'h11, 32'h0);
         hub_case(6'h00, 1, 32'h41, 32'h66, 0);
         hub_case(6'h00, 1, 32'h43, 32'h88, 0);
         hub_case(6'h01, 1, 32'h43, 32'h8877, 0);
         hub_case(6'h01, 1, 32'h41, 32'h6655, 0);
         hub_case(6'h02, 1, 32'h43, 32'h8877_6655, 0);
         hub_case(6'h02, 0, 32'hFFFF_0047, 32'h0, 1);
         hub_case(6'h00, 0, 32'h0000_0045, 32'h0, 1);
      end
   endtask

   // write forms and unknown opcodes must not run
   task t_refuse;
      reg [5:0] ops [0:2];
      integer k;
      begin
         ops[0] = 6'h00;
         ops[1] = 6'h02;
         ops[2] = 6'h3F;
         for (k = 0; k < 3; k = k + 1)
         begin
            wb(1'b1, 12'h000, {ops[k], 3'b110, 1'b1, 4'hF, 18'h00A40});
            check_val(busy_o, 32'h0);
            wb(1'b0, 12'h008, 32'h0);
            check_val(rd & 32'h4, 32'h4);
            wb(1'b1, 12'h008, 32'h4);
         end
      end
   endtask

   always @(posedge clk_i)
   begin
      cyc_cnt = cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         n_errors = n_errors + 1;
         summarize;
      end
   end

   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_rotate_left;
      t_rotate_right;
      t_count_source;
      t_no_result;
      t_hub_reads;
      t_refuse;
      summarize;
   end
endmodule
